// file: rtl/piyo_pkg.sv
// Purpose: Constants and types for the port-input and pointer-increment execution block.
// Assumes: One instruction word is offered per machine cycle, one clock per cycle.
// Notes:   Operation
// Operation
// (RQ1) First-port input loads all accumulator bits.
// (RQ2) Second-port input loads all accumulator bits.
// (RQ3) Third-port bits go to accumulator bits 1,0.
// (RQ4) Third-port input clears accumulator bits 3,2.
// (RQ5) Bit-port level goes to accumulator bit 0.
// (RQ6) Bit-port input clears accumulator bits 3..1.
// (RQ7) Pointer increment adds one to pointer.
// (RQ8) Zero pointer after increment skips next instruction.
// (RQ9) Four-bit pointer wraps; one word, one cycle.
package piyo_pkg;

    // Word and register widths.
    localparam int OPC_W = 10;
    localparam int ACC_W = 4;
    localparam int PTR_W = 4;
    localparam int THIRD_W = 2;

    // Opcode values of the instruction group.
    localparam logic [OPC_W-1:0] OPC_FIRST = 10'h260;
    localparam logic [OPC_W-1:0] OPC_SECOND_DEF = 10'h261;
    localparam logic [OPC_W-1:0] OPC_THIRD = 10'h262;
    localparam logic [OPC_W-1:0] OPC_BIT = 10'h26F;
    localparam logic [OPC_W-1:0] OPC_INC = 10'h013;

    // Values after reset, and the pointer step and zero constants.
    localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;

    // Decoded operation classes.
    typedef enum logic [2:0] {
        PIYO_OP_NONE   = 3'h0,
        PIYO_OP_FIRST  = 3'h1,
        PIYO_OP_SECOND = 3'h3,
        PIYO_OP_THIRD  = 3'h2,
        PIYO_OP_BIT    = 3'h6,
        PIYO_OP_INC    = 3'h7
    } piyo_op_e;

endpackage : piyo_pkg

// file: rtl/piyo_decode.sv
// Purpose: Maps an instruction word onto the operation class of this group.
// Assumes: Words outside the group decode to no operation.
// Notes:   Purely combinational; the caller registers the effects.
`timescale 1ns/1ps
`default_nettype none
module piyo_decode #(
    parameter logic [piyo_pkg::OPC_W-1:0] OPC_SECOND = piyo_pkg::OPC_SECOND_DEF
) (
    // Instruction word.
    input  wire logic [piyo_pkg::OPC_W-1:0] instr,
    // Decoded class.
    output var piyo_pkg::piyo_op_e           op
);

    // Compares the word against each opcode of the group.
    always_comb begin
        case (instr)
            piyo_pkg::OPC_FIRST: op = piyo_pkg::PIYO_OP_FIRST;
            OPC_SECOND:          op = piyo_pkg::PIYO_OP_SECOND;
            piyo_pkg::OPC_THIRD: op = piyo_pkg::PIYO_OP_THIRD;
            piyo_pkg::OPC_BIT:   op = piyo_pkg::PIYO_OP_BIT;
            piyo_pkg::OPC_INC:   op = piyo_pkg::PIYO_OP_INC;
            default:             op = piyo_pkg::PIYO_OP_NONE;
        endcase
    end

endmodule : piyo_decode
`default_nettype wire

// file: rtl/piyo_exec.sv
// Purpose: Executes the port-input and pointer-increment instructions of a 4-bit core.
// Assumes: Port pins are synchronous to clk; one instr_valid pulse per machine cycle.
// Notes:   A skipped instruction has no effect and clears the pending skip.
`timescale 1ns/1ps
`default_nettype none
module piyo_exec #(
    parameter logic [piyo_pkg::OPC_W-1:0] OPC_SECOND = piyo_pkg::OPC_SECOND_DEF
) (
    // Clock and reset.
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Instruction offered by fetch.
    input  wire logic                        instr_valid,
    input  wire logic [piyo_pkg::OPC_W-1:0]  instr,
    // Port input pins.
    input  wire logic [piyo_pkg::ACC_W-1:0]  first_general_port,
    input  wire logic [piyo_pkg::ACC_W-1:0]  second_general_port,
    input  wire logic [piyo_pkg::THIRD_W-1:0] third_general_port,
    input  wire logic                        bit_port,
    // Loads from the rest of the core.
    input  wire logic                        acc_load_en,
    input  wire logic [piyo_pkg::ACC_W-1:0]  acc_load_val,
    input  wire logic                        ptr_load_en,
    input  wire logic [piyo_pkg::PTR_W-1:0]  ptr_load_val,
    // Register state and status.
    output logic      [piyo_pkg::ACC_W-1:0]  acc_r,
    output logic      [piyo_pkg::PTR_W-1:0]  ptr_r,
    output logic                             skip_pending_r,
    output logic                             exec_done_r,
    output logic                             skipped_r
);

    // Refuses an opcode that collides with another of the group.
    if (OPC_SECOND == piyo_pkg::OPC_FIRST || OPC_SECOND == piyo_pkg::OPC_THIRD ||
        OPC_SECOND == piyo_pkg::OPC_BIT || OPC_SECOND == piyo_pkg::OPC_INC) begin : g_chk
        $error("Second-port opcode collides with another opcode.");
    end

    piyo_pkg::piyo_op_e                op;
    logic                              exec;
    logic [piyo_pkg::ACC_W-1:0]        acc_nxt;
    logic [piyo_pkg::PTR_W-1:0]        ptr_nxt;
    logic [piyo_pkg::PTR_W-1:0]        ptr_inc;
    logic                              skip_nxt;
    logic                              done_nxt;
    logic                              skipped_nxt;

    // Decodes the offered word.
    piyo_decode #(
        .OPC_SECOND (OPC_SECOND)
    ) u_decode (
        .instr (instr),
        .op    (op)
    );

    // An offered word runs unless a skip is pending.
    assign exec = instr_valid && !skip_pending_r;
    assign ptr_inc = ptr_r + piyo_pkg::PTR_ONE;

    // Computes the next accumulator, pointer and skip state.
    always_comb begin
        acc_nxt = acc_load_en ? acc_load_val : acc_r;
        ptr_nxt = ptr_load_en ? ptr_load_val : ptr_r;
        skip_nxt = skip_pending_r;
        done_nxt = 1'b0;
        skipped_nxt = 1'b0;
        if (instr_valid && skip_pending_r) begin
            // (RQ8) Skip consumed here.
            skip_nxt = 1'b0;
            skipped_nxt = 1'b1;
        end else if (exec) begin
            // (RQ9) One cycle each.
            done_nxt = 1'b1;
            case (op)
                // (RQ1) First port load.
                piyo_pkg::PIYO_OP_FIRST: acc_nxt = first_general_port;
                // (RQ2) Second port load.
                piyo_pkg::PIYO_OP_SECOND: acc_nxt = second_general_port;
                // (RQ3) (RQ4) Third port, upper cleared.
                piyo_pkg::PIYO_OP_THIRD: acc_nxt = {2'h0, third_general_port};
                // (RQ5) (RQ6) Bit port, upper cleared.
                piyo_pkg::PIYO_OP_BIT: acc_nxt = {3'h0, bit_port};
                piyo_pkg::PIYO_OP_INC: begin
                    // (RQ7) Pointer plus one.
                    ptr_nxt = ptr_inc;
                    // (RQ8) Zero result arms skip.
                    skip_nxt = (ptr_inc == piyo_pkg::PTR_ZERO);
                end
                // Words outside the group only report completion.
                default: skipped_nxt = 1'b0;
            endcase
        end
    end

    // Registers the execution state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= piyo_pkg::ACC_RST;
            ptr_r <= piyo_pkg::PTR_RST;
            skip_pending_r <= 1'b0;
            exec_done_r <= 1'b0;
            skipped_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            ptr_r <= ptr_nxt;
            skip_pending_r <= skip_nxt;
            exec_done_r <= done_nxt;
            skipped_r <= skipped_nxt;
        end
    end

    // Checks the execution results one cycle after the word is taken.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    first_load_a: assert property ( // (RQ1)
        exec && op == piyo_pkg::PIYO_OP_FIRST |=> acc_r == $past(first_general_port))
        else $error("First port not loaded into accumulator.");
    second_load_a: assert property ( // (RQ2)
        exec && op == piyo_pkg::PIYO_OP_SECOND |=> acc_r == $past(second_general_port))
        else $error("Second port not loaded into accumulator.");
    third_low_a: assert property ( // (RQ3)
        exec && op == piyo_pkg::PIYO_OP_THIRD |=> acc_r[1:0] == $past(third_general_port))
        else $error("Third port bits misplaced.");
    third_high_a: assert property ( // (RQ4)
        exec && op == piyo_pkg::PIYO_OP_THIRD |=> acc_r[3:2] == 2'h0)
        else $error("Third port input left upper bits set.");
    bit_low_a: assert property ( // (RQ5)
        exec && op == piyo_pkg::PIYO_OP_BIT |=> acc_r[0] == $past(bit_port))
        else $error("Bit port level not in bit zero.");
    bit_high_a: assert property ( // (RQ6)
        exec && op == piyo_pkg::PIYO_OP_BIT |=> acc_r[3:1] == 3'h0)
        else $error("Bit port input left upper bits set.");
    ptr_inc_a: assert property ( // (RQ7)
        exec && op == piyo_pkg::PIYO_OP_INC |=> ptr_r == $past(ptr_inc) && exec_done_r)
        else $error("Pointer not incremented.");
    ptr_wrap_a: assert property ( // (RQ9)
        exec && op == piyo_pkg::PIYO_OP_INC && ptr_r == 4'hF |=> ptr_r == 4'h0)
        else $error("Pointer did not wrap to zero.");
    skip_arm_a: assert property ( // (RQ8)
        exec && op == piyo_pkg::PIYO_OP_INC |=>
            skip_pending_r == (ptr_r == piyo_pkg::PTR_ZERO))
        else $error("Skip flag disagrees with pointer.");
    skip_take_a: assert property ( // (RQ8)
        skip_pending_r && instr_valid |=> skipped_r && !exec_done_r && !skip_pending_r)
        else $error("Pending skip not applied to next word.");

    // Main scenarios.
    inc_wrap_c: cover property (exec && op == piyo_pkg::PIYO_OP_INC && ptr_r == 4'hF);
    skip_done_c: cover property (skip_pending_r && instr_valid ##1 skipped_r);
    third_in_c: cover property (exec && op == piyo_pkg::PIYO_OP_THIRD);
    bit_in_c: cover property (exec && op == piyo_pkg::PIYO_OP_BIT);

endmodule : piyo_exec
`default_nettype wire

// file: verification/piyo_port_pins.sv
// Purpose: Model of the external drivers on the four input ports.
// Assumes: One pattern word from the bench sets every pin level.
// Notes:   Each port shows a different slice or the inverted pattern, so a swapped port shows up at once.
`timescale 1ns/1ps
`default_nettype none
module piyo_port_pins (
    // Pattern chosen by the bench.
    input  wire logic [3:0] pat,
    // Port pins.
    output logic      [3:0] first_general_port,
    output logic      [3:0] second_general_port,
    output logic      [1:0] third_general_port,
    output logic            bit_port
);
    // The pins follow the pattern at once, as static external levels.
    assign first_general_port  = pat;
    assign second_general_port = ~pat;
    assign third_general_port  = pat[3:2];
    assign bit_port            = pat[1];
endmodule : piyo_port_pins
`default_nettype wire

// file: verification/port_input_and_y_increment_ops_tb_top.sv
// Purpose: Self-checking bench for the port-input and pointer-increment block.
// Assumes: Inputs change at the falling edge of clk.
// Notes:   Port pin levels come from the partner model.
`timescale 1ns/1ps
`default_nettype none
module port_input_and_y_increment_ops_tb_top;
    logic       clk, rst, vld, acc_en, ptr_en, pk, skp, done, skd;
    logic [9:0] instr;
    logic [3:0] pat, acc_val, ptr_val, p0, p1, acc, ptr;
    logic [1:0] p2;
    int         fail_count, check_count, cycles;

    // Block under test and its port drivers.
    piyo_exec i_piyo_exec (.clk(clk), .rst(rst), .instr_valid(vld), .instr(instr),
        .first_general_port(p0), .second_general_port(p1), .third_general_port(p2),
        .bit_port(pk), .acc_load_en(acc_en), .acc_load_val(acc_val), .ptr_load_en(ptr_en),
        .ptr_load_val(ptr_val), .acc_r(acc), .ptr_r(ptr), .skip_pending_r(skp),
        .exec_done_r(done), .skipped_r(skd));
    piyo_port_pins i_piyo_port_pins (.pat(pat), .first_general_port(p0),
        .second_general_port(p1), .third_general_port(p2), .bit_port(pk));

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Offers one word for one cycle with the given pin pattern.
    task automatic issue(input logic [9:0] w, input logic [3:0] p);
        @(negedge clk);
        vld   = 1'b1;
        instr = w;
        pat   = p;
        @(negedge clk);
        vld   = 1'b0;
    endtask : issue

    // Loads accumulator and pointer from the rest of the core.
    task automatic preload(input logic [3:0] a, input logic [3:0] p);
        @(negedge clk);
        {acc_en, ptr_en, acc_val, ptr_val} = {2'b11, a, p};
        @(negedge clk);
        {acc_en, ptr_en} = 2'b00;
    endtask : preload

    // Each port input word; all but the second-port word start from an accumulator preloaded with all ones.
    task automatic port_loads();
        preload(4'hF, 4'h0);
        issue(piyo_pkg::OPC_FIRST, 4'hA);
        chk("acc first", 4'hA, acc);
        chk("done", 4'h1, {3'h0, done});
        issue(piyo_pkg::OPC_SECOND_DEF, 4'hA);
        chk("acc second", 4'h5, acc);
        preload(4'hF, 4'h0);
        issue(piyo_pkg::OPC_THIRD, 4'h9);
        chk("acc third", 4'h2, acc);
        preload(4'hF, 4'h0);
        issue(piyo_pkg::OPC_BIT, 4'h2);
        chk("acc bit", 4'h1, acc);
    endtask : port_loads

    // Increment without and with wrap, then the skipped word.
    task automatic inc_skip();
        preload(4'h0, 4'h3);
        issue(piyo_pkg::OPC_INC, 4'h0);
        chk("ptr", 4'h4, ptr);
        chk("skip", 4'h0, {3'h0, skp});
        preload(4'h0, 4'hF);
        issue(piyo_pkg::OPC_INC, 4'h0);
        chk("ptr wrap", 4'h0, ptr);
        chk("skip", 4'h1, {3'h0, skp});
        issue(piyo_pkg::OPC_FIRST, 4'hC);
        chk("acc skipped", 4'h0, acc);
        chk("skipped", 4'h1, {3'h0, skd});
        chk("skip", 4'h0, {3'h0, skp});
    endtask : inc_skip

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Clock of 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hang short well past the expected run length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            fail_count++;
            stop_test();
        end
    end

    // Main sequence.
    initial begin
        {rst, vld, acc_en, ptr_en, instr, pat, acc_val, ptr_val} = {1'b1, 25'h0};
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("acc reset", 4'h0, acc);
        chk("ptr reset", 4'h0, ptr);
        port_loads();
        inc_skip();
        stop_test();
    end
endmodule : port_input_and_y_increment_ops_tb_top
`default_nettype wire
